// ---- csb_unit.sv ----
// Top of the compare, skip and branch execution slice with its APB registers
//
// The register offsets and the APB register port were decided locally.
`default_nettype none

module csb_unit
	import csb_pkg::*;
(
	// Clock and reset
	input  wire logic         SYS_CLK_IN,
	input  wire logic         RESETN_IN,
	// Instruction request
	input  wire logic         REQ_VALID_IN,
	input  wire csb_req_type  REQ_IN,
	output logic              READY_OUT,
	// Instruction result
	output csb_resp_type      RESP_OUT,
	// APB slave
	input  wire logic         PSEL_IN,
	input  wire logic         PENABLE_IN,
	input  wire logic         PWRITE_IN,
	input  wire logic [7:0]   PADDR_IN,
	input  wire logic [31:0]  PWDATA_IN,
	output logic [31:0]       PRDATA_OUT,
	output logic              PREADY_OUT,
	output logic              PSLVERR_OUT
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	typedef enum logic [0:0] {
		ST_IDLE   = 1'b0,
		ST_ANSWER = 1'b1
	} csb_state_type;

	csb_state_type            state;
	csb_state_type            next_state;
	csb_resp_type             resp;
	csb_resp_type             next_resp;
	logic                     ready;
	logic                     next_ready;
	logic                     enable;
	logic                     next_enable;
	logic [15:0]              taken_count;
	logic [15:0]              next_taken_count;
	logic                     last_taken;
	logic                     next_last_taken;
	logic [4:0]               last_op;
	logic [4:0]               next_last_op;
	logic [31:0]              prdata;
	logic [31:0]              next_prdata;
	logic                     pready;
	logic                     next_pready;
	logic                     pslverr;
	logic                     next_pslverr;

	logic                     accept;
	logic                     sub_c;
	logic                     sub_z;
	logic                     sub_n;
	logic                     sub_v;
	logic                     sub_h;
	logic [7:0]               sub_b;
	logic                     sub_borrow;
	logic                     is_chain;
	logic [CSB_PC_W-1:0]      branch_target;
	logic [CSB_PC_W-1:0]      skip_target;
	logic [CSB_PC_W-1:0]      next_pc;
	logic                     reg_bit;
	logic                     io_bit;
	logic                     sel_flag;
	logic                     apb_access;
	logic                     apb_write;

	// Instruction taken when idle and enabled by software
	assign accept = REQ_VALID_IN & ready & enable;

	// ****************************************************************
	// Compare arithmetic
	// ****************************************************************
	assign is_chain   = (REQ_IN.op == OP_COMPARE_WITH_BORROW);
	// Immediate form compares against the constant, borrow form against rr and carry
	assign sub_b      = is_chain ? REQ_IN.rr : REQ_IN.imm;
	assign sub_borrow = is_chain & REQ_IN.status_flags_word[CSB_FLAG_C];

	csb_sub_flags u_sub (
		.a_in          (REQ_IN.rd),
		.b_in          (sub_b),
		.borrow_in     (sub_borrow),
		.zero_prev_in  (REQ_IN.status_flags_word[CSB_FLAG_Z]),
		.chain_zero_in (is_chain),
		.c_out         (sub_c),
		.z_out         (sub_z),
		.n_out         (sub_n),
		.v_out         (sub_v),
		.h_out         (sub_h)
	);

	// ****************************************************************
	// Program counter targets and tested bits
	// ****************************************************************
	assign branch_target = REQ_IN.pc
		+ {{(CSB_PC_W-CSB_OFF_W){REQ_IN.offset[CSB_OFF_W-1]}}, REQ_IN.offset}
		+ CSB_STEP_NEXT;
	// Step over the following instruction, one or two words long
	assign skip_target = REQ_IN.pc
		+ (REQ_IN.two_word_next ? CSB_STEP_SKIP2 : CSB_STEP_SKIP1);
	assign next_pc  = REQ_IN.pc + CSB_STEP_NEXT;
	assign reg_bit  = REQ_IN.rd[REQ_IN.bit_sel];
	assign io_bit   = REQ_IN.io[REQ_IN.bit_sel];
	assign sel_flag = REQ_IN.status_flags_word[REQ_IN.flag_sel];

	// ****************************************************************
	// Execution: next result, state and statistics
	// ****************************************************************
	always_comb begin
		logic take;
		logic is_skip;
		take = 1'b0;
		is_skip = 1'b0;
		next_resp = resp;
		next_resp.done = 1'b0;
		next_resp.flags_we = 1'b0;
		next_state = ST_IDLE;
		next_ready = 1'b1;
		next_last_taken = last_taken;
		next_last_op = last_op;
		next_taken_count = taken_count;
		if (accept) begin
			case (REQ_IN.op)
				OP_SKIP_REG_BIT_CLEAR: begin
					is_skip = 1'b1;
					take = ~reg_bit;
				end
				OP_SKIP_REG_BIT_SET: begin
					is_skip = 1'b1;
					take = reg_bit;
				end
				OP_SKIP_IO_BIT_CLEAR: begin
					is_skip = 1'b1;
					take = ~io_bit;
				end
				OP_SKIP_IO_BIT_SET: begin
					is_skip = 1'b1;
					take = io_bit;
				end
				OP_BRANCH_FLAG_SET: take = sel_flag;
				OP_BRANCH_FLAG_CLEAR: take = ~sel_flag;
				OP_BRANCH_EQUAL: take = REQ_IN.status_flags_word[CSB_FLAG_Z];
				OP_BRANCH_NOT_EQUAL: take = ~REQ_IN.status_flags_word[CSB_FLAG_Z];
				OP_BRANCH_CARRY_SET,
				OP_BRANCH_LOWER: take = REQ_IN.status_flags_word[CSB_FLAG_C];
				OP_BRANCH_CARRY_CLEAR: take = ~REQ_IN.status_flags_word[CSB_FLAG_C];
				OP_BRANCH_SAME_OR_HIGHER: take = ~REQ_IN.status_flags_word[CSB_FLAG_C];
				OP_BRANCH_MINUS: take = REQ_IN.status_flags_word[CSB_FLAG_N];
				OP_BRANCH_PLUS: take = ~REQ_IN.status_flags_word[CSB_FLAG_N];
				default: take = 1'b0;
			endcase
			next_resp.done = 1'b1;
			next_resp.taken = take;
			next_resp.status_flags_word = REQ_IN.status_flags_word;
			if (REQ_IN.op == OP_COMPARE_IMMEDIATE || is_chain) begin
				// Difference discarded, only the five flags move
				next_resp.flags_we = 1'b1;
				next_resp.status_flags_word[CSB_FLAG_C] = sub_c;
				next_resp.status_flags_word[CSB_FLAG_Z] = sub_z;
				next_resp.status_flags_word[CSB_FLAG_N] = sub_n;
				next_resp.status_flags_word[CSB_FLAG_V] = sub_v;
				next_resp.status_flags_word[CSB_FLAG_H] = sub_h;
			end
			if (!take) begin
				next_resp.pc = next_pc;
			end else if (is_skip) begin
				next_resp.pc = skip_target;
			end else begin
				next_resp.pc = branch_target;
			end
			next_state = ST_ANSWER;
			next_ready = 1'b0;
			next_last_taken = take;
			next_last_op = REQ_IN.op;
		end
		// Counter clear from the bus comes first, a taken event in the same cycle still counts
		if (apb_write && PADDR_IN == CSB_ADDR_COUNT) begin
			next_taken_count = CSB_COUNT_RESET;
		end
		if (accept && take) begin
			next_taken_count = next_taken_count + 16'h0001;
		end
		case (state)
			ST_IDLE: ;
			ST_ANSWER: ;
			default: next_state = ST_IDLE;
		endcase
	end

	// Execution registers
	always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			state <= ST_IDLE;
			resp <= '0;
			ready <= 1'b1;
			last_taken <= 1'b0;
			last_op <= 5'h00;
			taken_count <= CSB_COUNT_RESET;
		end else begin
			state <= next_state;
			resp <= next_resp;
			ready <= next_ready;
			last_taken <= next_last_taken;
			last_op <= next_last_op;
			taken_count <= next_taken_count;
		end
	end

	assign READY_OUT = ready;
	assign RESP_OUT  = resp;

	// ****************************************************************
	// APB register slave
	// ****************************************************************
	assign apb_access = PSEL_IN & PENABLE_IN & ~pready;
	// Writes land only on the edge that completes the transfer, with pready high
	assign apb_write  = PSEL_IN & PENABLE_IN & pready & PWRITE_IN;

	// Answer one cycle into the access phase, error on unmapped words
	always_comb begin
		next_pready = apb_access;
		next_pslverr = 1'b0;
		next_prdata = 32'h0000_0000;
		next_enable = enable;
		if (apb_access) begin
			case (PADDR_IN)
				CSB_ADDR_CTRL: next_prdata = {31'h0000_0000, enable};
				CSB_ADDR_STATUS: begin
					next_prdata = {16'h0000, resp.status_flags_word, last_op,
						last_taken, ~ready, ready};
				end
				CSB_ADDR_COUNT: next_prdata = {16'h0000, taken_count};
				default: next_pslverr = 1'b1;
			endcase
		end
		// Enable bit follows the completed write
		if (apb_write && PADDR_IN == CSB_ADDR_CTRL) begin
			next_enable = PWDATA_IN[CSB_CTRL_ENABLE];
		end
	end

	// Bus registers
	always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			enable <= CSB_CTRL_RESET;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			enable <= next_enable;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	assign PRDATA_OUT  = prdata;
	assign PREADY_OUT  = pready;
	assign PSLVERR_OUT = pslverr;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge SYS_CLK_IN); endclocking
	default disable iff (!RESETN_IN);

	AST_CMP_IMM_ZERO: assert property (
		accept && REQ_IN.op == OP_COMPARE_IMMEDIATE |=> RESP_OUT.done && RESP_OUT.flags_we
		&& RESP_OUT.status_flags_word[CSB_FLAG_Z] == ($past(REQ_IN.rd) == $past(REQ_IN.imm)))
		else $error("compare immediate zero flag wrong");

	AST_CMP_BORROW_CARRY: assert property (
		accept && REQ_IN.op == OP_COMPARE_WITH_BORROW |=>
		RESP_OUT.status_flags_word[CSB_FLAG_C] == ({1'b0, $past(REQ_IN.rd)} <
		{1'b0, $past(REQ_IN.rr)} + {8'h00, $past(REQ_IN.status_flags_word[CSB_FLAG_C])}))
		else $error("compare with borrow carry wrong");

	AST_SKIP_REG_CLEAR: assert property (
		accept && REQ_IN.op == OP_SKIP_REG_BIT_CLEAR && !reg_bit |=>
		RESP_OUT.pc == $past(REQ_IN.pc) + ($past(REQ_IN.two_word_next) ? 16'h0003 : 16'h0002))
		else $error("register bit clear skip target wrong");

	AST_SKIP_REG_SET_FLAGS: assert property (
		accept && REQ_IN.op == OP_SKIP_REG_BIT_SET |=> !RESP_OUT.flags_we
		&& RESP_OUT.taken == $past(reg_bit)
		&& RESP_OUT.status_flags_word == $past(REQ_IN.status_flags_word))
		else $error("register bit set skip touched flags");

	AST_SKIP_IO_CLEAR_FALL: assert property (
		accept && REQ_IN.op == OP_SKIP_IO_BIT_CLEAR && io_bit |=>
		RESP_OUT.pc == $past(REQ_IN.pc) + 16'h0001 && !RESP_OUT.flags_we)
		else $error("io bit clear skip taken on set bit");

	AST_SKIP_IO_SET_TWO: assert property (
		accept && REQ_IN.op == OP_SKIP_IO_BIT_SET && io_bit && REQ_IN.two_word_next |=>
		RESP_OUT.pc == $past(REQ_IN.pc) + 16'h0003)
		else $error("io bit set skip over two words wrong");

	AST_BRANCH_FLAG: assert property (
		accept && (REQ_IN.op == OP_BRANCH_FLAG_SET || REQ_IN.op == OP_BRANCH_FLAG_CLEAR) |=>
		RESP_OUT.taken == ($past(sel_flag) == ($past(REQ_IN.op) == OP_BRANCH_FLAG_SET))
		&& RESP_OUT.pc == ($past(sel_flag) == ($past(REQ_IN.op) == OP_BRANCH_FLAG_SET) ?
		$past(branch_target) : $past(REQ_IN.pc) + 16'h0001))
		else $error("flag branch target wrong");

	AST_BRANCH_ZERO: assert property (
		accept && (REQ_IN.op == OP_BRANCH_EQUAL || REQ_IN.op == OP_BRANCH_NOT_EQUAL) |=>
		RESP_OUT.taken == ($past(REQ_IN.status_flags_word[CSB_FLAG_Z])
		== ($past(REQ_IN.op) == OP_BRANCH_EQUAL)))
		else $error("zero flag branch decision wrong");

	AST_BRANCH_CARRY: assert property (
		accept && (REQ_IN.op == OP_BRANCH_LOWER || REQ_IN.op == OP_BRANCH_SAME_OR_HIGHER
		|| REQ_IN.op == OP_BRANCH_CARRY_SET || REQ_IN.op == OP_BRANCH_CARRY_CLEAR)
		|=> RESP_OUT.taken == ($past(REQ_IN.status_flags_word[CSB_FLAG_C])
		== ($past(REQ_IN.op) == OP_BRANCH_LOWER || $past(REQ_IN.op) == OP_BRANCH_CARRY_SET))
		&& !RESP_OUT.flags_we)
		else $error("carry branch decision wrong");

	AST_BRANCH_SIGN: assert property (
		accept && REQ_IN.op == OP_BRANCH_PLUS && !REQ_IN.status_flags_word[CSB_FLAG_N]
		|=> RESP_OUT.taken && RESP_OUT.pc == $past(branch_target) ##1 !RESP_OUT.done)
		else $error("plus branch not taken");

endmodule

`default_nettype wire

// ---- csb_compare_core.sv ----
// Shared constants, types and the subtract-and-flag core of the compare unit
// Notes on behaviour
// - Compare-immediate subtracts constant from register, keeps no result, updates Z N V C H
// - Compare-with-borrow subtracts register and carry, keeps no result, updates Z N V C H
// - Skip when working register bit is zero; flags unchanged
// - Skip when working register bit is one; flags unchanged
// - Skip when I/O register bit is zero; flags unchanged
// - Skip when I/O register bit is one; flags unchanged
// - Branch to pc plus offset plus one when selected status bit is one
// - Branch to pc plus offset plus one when selected status bit is zero
// - Branch-equal is taken only when the zero flag is one
// - Branch-not-equal is taken only when the zero flag is zero
// - Branch-carry-set and branch-lower are taken only when carry is one
// - Branch-same-or-higher behaves exactly like branch-carry-clear
// - Branch-minus is taken only when the negative flag is one
// - Branch-plus is taken only when the negative flag is zero
`default_nettype none

package csb_pkg;

	// ****************************************************************
	// Widths and status bit positions
	// ****************************************************************
	localparam int CSB_PC_W    = 16;
	localparam int CSB_OFF_W   = 7;
	localparam int CSB_FLAG_C  = 0;
	localparam int CSB_FLAG_Z  = 1;
	localparam int CSB_FLAG_N  = 2;
	localparam int CSB_FLAG_V  = 3;
	localparam int CSB_FLAG_H  = 5;

	// ****************************************************************
	// Program counter steps
	// ****************************************************************
	localparam logic [CSB_PC_W-1:0] CSB_STEP_NEXT  = 16'h0001;
	localparam logic [CSB_PC_W-1:0] CSB_STEP_SKIP1 = 16'h0002;
	localparam logic [CSB_PC_W-1:0] CSB_STEP_SKIP2 = 16'h0003;

	// ****************************************************************
	// Register map and reset values
	// ****************************************************************
	localparam logic [7:0]  CSB_ADDR_CTRL    = 8'h00;
	localparam logic [7:0]  CSB_ADDR_STATUS  = 8'h04;
	localparam logic [7:0]  CSB_ADDR_COUNT   = 8'h08;
	localparam int          CSB_CTRL_ENABLE  = 0;
	localparam logic        CSB_CTRL_RESET   = 1'b1;
	localparam logic [15:0] CSB_COUNT_RESET  = 16'h0000;
	localparam logic [7:0]  CSB_FLAGS_RESET  = 8'h00;

	// Operations of this slice
	typedef enum logic [4:0] {
		OP_COMPARE_IMMEDIATE   = 5'h00,
		OP_COMPARE_WITH_BORROW = 5'h01,
		OP_SKIP_REG_BIT_CLEAR  = 5'h02,
		OP_SKIP_REG_BIT_SET    = 5'h03,
		OP_SKIP_IO_BIT_CLEAR   = 5'h04,
		OP_SKIP_IO_BIT_SET     = 5'h05,
		OP_BRANCH_FLAG_SET     = 5'h06,
		OP_BRANCH_FLAG_CLEAR   = 5'h07,
		OP_BRANCH_EQUAL        = 5'h08,
		OP_BRANCH_NOT_EQUAL    = 5'h09,
		OP_BRANCH_CARRY_SET    = 5'h0a,
		OP_BRANCH_LOWER        = 5'h0b,
		OP_BRANCH_CARRY_CLEAR  = 5'h0c,
		OP_BRANCH_SAME_OR_HIGHER = 5'h0d,
		OP_BRANCH_MINUS        = 5'h0e,
		OP_BRANCH_PLUS         = 5'h0f
	} csb_op_type;

	// Decoded instruction with its operands
	typedef struct packed {
		csb_op_type            op;
		logic [2:0]            bit_sel;
		logic [2:0]            flag_sel;
		logic [CSB_OFF_W-1:0]  offset;
		logic [7:0]            imm;
		logic [7:0]            rd;
		logic [7:0]            rr;
		logic [7:0]            io;
		logic [7:0]            status_flags_word;
		logic [CSB_PC_W-1:0]   pc;
		logic                  two_word_next;
	} csb_req_type;

	// Result handed back to the core
	typedef struct packed {
		logic                  done;
		logic                  flags_we;
		logic                  taken;
		logic [CSB_PC_W-1:0]   pc;
		logic [7:0]            status_flags_word;
	} csb_resp_type;

endpackage

// ****************************************************************
// Subtract with borrow and derive the compare flags
// ****************************************************************
module csb_sub_flags
	import csb_pkg::*;
(
	// Operands
	input  wire logic [7:0] a_in,
	input  wire logic [7:0] b_in,
	input  wire logic       borrow_in,
	input  wire logic       zero_prev_in,
	input  wire logic       chain_zero_in,
	// Flags
	output logic            c_out,
	output logic            z_out,
	output logic            n_out,
	output logic            v_out,
	output logic            h_out
);
	logic [7:0] diff;

	// Difference is only used for flags, never stored
	assign diff  = a_in - b_in - {7'h00, borrow_in};
	assign n_out = diff[7];
	assign c_out = (~a_in[7] & b_in[7]) | (b_in[7] & diff[7]) | (diff[7] & ~a_in[7]);
	assign h_out = (~a_in[3] & b_in[3]) | (b_in[3] & diff[3]) | (diff[3] & ~a_in[3]);
	assign v_out = (a_in[7] & ~b_in[7] & ~diff[7]) | (~a_in[7] & b_in[7] & diff[7]);
	// Chained compares keep zero only if the lower part was zero too
	assign z_out = (diff == 8'h00) & (~chain_zero_in | zero_prev_in);

endmodule

`default_nettype wire

// ---- csb_unit_tb_top.sv ----
// Self-checking testbench of the compare, skip and branch slice
`default_nettype none

`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
	$display("MISMATCH %s expected %h seen %h", nm, e, g); end end

module csb_unit_tb_top
	import csb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************************************
	// Signals and bookkeeping
	// ****************************************************************
	typedef struct {
		csb_req_type  req;
		csb_resp_type exp;
	} csb_note_type;

	logic         clk;
	logic         rst_n;
	logic         req_valid;
	csb_req_type  req;
	logic         ready;
	csb_resp_type resp;
	logic         psel;
	logic         penable;
	logic         pwrite;
	logic [7:0]   paddr;
	logic [31:0]  pwdata;
	logic [31:0]  prdata;
	logic         pready;
	logic         pslverr;
	logic [31:0]  seed;
	logic [31:0]  rdata;
	logic         err;
	int           mismatches;
	int           checks_done;
	int           sent;
	csb_note_type notes[$];
	csb_note_type note;
	csb_note_type last;
	csb_req_type  r;

	csb_unit csb_unit_i (
		.SYS_CLK_IN   (clk),
		.RESETN_IN    (rst_n),
		.REQ_VALID_IN (req_valid),
		.REQ_IN       (req),
		.READY_OUT    (ready),
		.RESP_OUT     (resp),
		.PSEL_IN      (psel),
		.PENABLE_IN   (penable),
		.PWRITE_IN    (pwrite),
		.PADDR_IN     (paddr),
		.PWDATA_IN    (pwdata),
		.PRDATA_OUT   (prdata),
		.PREADY_OUT   (pready),
		.PSLVERR_OUT  (pslverr)
	);

	// ****************************************************************
	// Reference model and random source
	// ****************************************************************
	function automatic logic [31:0] nxt();
		seed = (seed >> 1) ^ ({32{seed[0]}} & 32'h80200003);
		return seed;
	endfunction

	function automatic csb_req_type rnd_req();
		logic [95:0] w;
		csb_req_type q;
		w = {nxt(), nxt(), nxt()};
		q = w[$bits(csb_req_type)-1:0];
		q.op = csb_op_type'({1'b0, w[3:0]});
		return q;
	endfunction

	function automatic csb_resp_type model(input csb_req_type q);
		csb_resp_type e;
		logic [7:0]   f;
		logic [7:0]   b;
		logic         cin;
		logic         c;
		logic [8:0]   full;
		logic [4:0]   half;
		f = q.status_flags_word;
		e = '0;
		e.done = 1'b1;
		e.status_flags_word = f;
		e.pc = q.pc + CSB_STEP_NEXT;
		c = 1'b0;
		b = (q.op == OP_COMPARE_IMMEDIATE) ? q.imm : q.rr;
		cin = (q.op == OP_COMPARE_IMMEDIATE) ? 1'b0 : f[CSB_FLAG_C];
		full = {1'b0, q.rd} - {1'b0, b} - {8'h00, cin};
		half = {1'b0, q.rd[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
		case (q.op)
			OP_COMPARE_IMMEDIATE, OP_COMPARE_WITH_BORROW: begin
				e.flags_we = 1'b1;
				e.status_flags_word[CSB_FLAG_C] = full[8];
				e.status_flags_word[CSB_FLAG_H] = half[4];
				e.status_flags_word[CSB_FLAG_N] = full[7];
				e.status_flags_word[CSB_FLAG_V] = (q.rd[7] ^ b[7]) & (q.rd[7] ^ full[7]);
				e.status_flags_word[CSB_FLAG_Z] = (full[7:0] == 8'h00) &
					((q.op == OP_COMPARE_IMMEDIATE) | f[CSB_FLAG_Z]);
			end
			OP_SKIP_REG_BIT_CLEAR: c = ~q.rd[q.bit_sel];
			OP_SKIP_REG_BIT_SET: c = q.rd[q.bit_sel];
			OP_SKIP_IO_BIT_CLEAR: c = ~q.io[q.bit_sel];
			OP_SKIP_IO_BIT_SET: c = q.io[q.bit_sel];
			OP_BRANCH_FLAG_SET: c = f[q.flag_sel];
			OP_BRANCH_FLAG_CLEAR: c = ~f[q.flag_sel];
			OP_BRANCH_EQUAL: c = f[CSB_FLAG_Z];
			OP_BRANCH_NOT_EQUAL: c = ~f[CSB_FLAG_Z];
			OP_BRANCH_CARRY_SET, OP_BRANCH_LOWER: c = f[CSB_FLAG_C];
			OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_OR_HIGHER: c = ~f[CSB_FLAG_C];
			OP_BRANCH_MINUS: c = f[CSB_FLAG_N];
			default: c = ~f[CSB_FLAG_N];
		endcase
		e.taken = c;
		if (c && q.op <= OP_SKIP_IO_BIT_SET) begin
			e.pc = q.pc + (q.two_word_next ? CSB_STEP_SKIP2 : CSB_STEP_SKIP1);
		end else if (c) begin
			e.pc = q.pc + {{(CSB_PC_W-CSB_OFF_W){q.offset[CSB_OFF_W-1]}}, q.offset}
				+ CSB_STEP_NEXT;
		end
		return e;
	endfunction

	// ****************************************************************
	// Drivers: instruction port and APB master
	// ****************************************************************
	// Leaves the request up so a following call lands in the answer cycle
	task automatic send(input csb_req_type q);
		req_valid <= 1'b1;
		req <= q;
		notes.push_back('{q, model(q)});
		last = notes[$];
		sent += int'(last.exp.taken); // Counter counts taken instructions only
		// Waits for ready; only the watchdog ends a hung wait
		@(posedge clk);
		while (ready !== 1'b1) begin
			@(posedge clk);
		end
	endtask

	task automatic idle();
		req_valid <= 1'b0;
		@(posedge clk);
	endtask

	task automatic drain();
		idle();
		while (notes.size() != 0) begin
			@(posedge clk);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle edge keeps the next setup off this time step
		@(posedge clk);
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ****************************************************************
	// Monitor: each answer is matched with the oldest note
	// ****************************************************************
	always @(posedge clk) begin
		if (rst_n === 1'b1 && resp.done === 1'b1) begin
			if (notes.size() == 0) begin
				mismatches++;
				$display("MISMATCH done expected 0 seen 1");
			end else begin
				note = notes.pop_front();
				if (note.req.op <= OP_COMPARE_WITH_BORROW) begin
					`CHK("flags", note.exp.status_flags_word, resp.status_flags_word)
					`CHK("flags_we", 1'b1, resp.flags_we)
					`CHK("pc", note.exp.pc, resp.pc)
				end else if (note.req.op <= OP_SKIP_IO_BIT_SET) begin
					`CHK("pc", note.exp.pc, resp.pc)
					`CHK("taken", note.exp.taken, resp.taken)
					`CHK("flags_we", 1'b0, resp.flags_we)
				end else begin
					`CHK("pc", note.exp.pc, resp.pc)
					`CHK("taken", note.exp.taken, resp.taken)
					`CHK("flags", note.exp.status_flags_word, resp.status_flags_word)
				end
			end
		end
	end

	// ****************************************************************
	// Clock, watchdog and main sequence
	// ****************************************************************
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		test_done();
	end

	initial begin
		rst_n = 1'b0;
		req_valid = 1'b0;
		req = '0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		seed = 32'h4c88;
		mismatches = 0;
		checks_done = 0;
		sent = 0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		// Reset values and an unmapped address
		apb(1'b0, CSB_ADDR_CTRL, 32'h0);
		`CHK("ctrl", CSB_CTRL_RESET, rdata[CSB_CTRL_ENABLE])
		apb(1'b0, CSB_ADDR_COUNT, 32'h0);
		`CHK("count", CSB_COUNT_RESET, rdata[15:0])
		apb(1'b1, 8'h0c, 32'hffffffff);
		`CHK("slverr", 1'b1, err)
		apb(1'b0, 8'h0c, 32'h0);
		`CHK("unmapped", 32'h0, rdata)
		$display("test registers done");
		// Every operation with random operands, some back to back
		for (int i = 0; i < 160; i++) begin
			r = rnd_req();
			r.op = csb_op_type'(5'(i % 16));
			send(r);
			if (i % 3 == 0) idle();
		end
		$display("test random ops done");
		// Boundaries: overflow, equality, chained zero, offsets, pc wrap, skip length
		r.op = OP_COMPARE_IMMEDIATE;
		r.rd = 8'h80;
		r.imm = 8'h01;
		send(r);
		r.imm = 8'h80;
		send(r);
		r.op = OP_COMPARE_WITH_BORROW;
		r.rr = 8'h7f;
		r.status_flags_word = 8'h01;
		send(r);
		r.status_flags_word = 8'h03;
		send(r);
		r.op = OP_BRANCH_EQUAL;
		r.pc = 16'hffff;
		r.offset = 7'h3f;
		send(r);
		r.pc = 16'h0010;
		r.offset = 7'h40;
		send(r);
		r.op = OP_SKIP_IO_BIT_SET;
		r.io = 8'h80;
		r.bit_sel = 3'h7;
		r.two_word_next = 1'b1;
		send(r);
		r.two_word_next = 1'b0;
		send(r);
		drain();
		$display("test boundaries done");
		// Counter, status and clearing
		apb(1'b0, CSB_ADDR_COUNT, 32'h0);
		`CHK("count", sent[15:0], rdata[15:0])
		apb(1'b0, CSB_ADDR_STATUS, 32'h0);
		`CHK("status", {last.exp.status_flags_word, last.req.op, last.exp.taken, 2'b01},
			rdata[15:0])
		apb(1'b1, CSB_ADDR_COUNT, 32'h1234);
		apb(1'b0, CSB_ADDR_COUNT, 32'h0);
		`CHK("count clear", 16'h0000, rdata[15:0])
		$display("test counter done");
		// Disabled: requests are ignored, then taken again
		apb(1'b1, CSB_ADDR_CTRL, 32'h0);
		req <= rnd_req();
		req_valid <= 1'b1;
		repeat (6) @(posedge clk);
		idle();
		apb(1'b0, CSB_ADDR_COUNT, 32'h0);
		`CHK("count disabled", 16'h0000, rdata[15:0])
		apb(1'b1, CSB_ADDR_CTRL, 32'h1);
		sent = 0;
		r = rnd_req();
		r.op = OP_BRANCH_FLAG_SET;
		r.flag_sel = 3'h0;
		r.status_flags_word = 8'h01;
		send(r);
		drain();
		apb(1'b0, CSB_ADDR_COUNT, 32'h0);
		`CHK("count enabled", 16'h0001, rdata[15:0])
		$display("test enable done");
		// Reset in mid-run restores the registers
		apb(1'b1, CSB_ADDR_CTRL, 32'h0);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, CSB_ADDR_CTRL, 32'h0);
		`CHK("ctrl after reset", CSB_CTRL_RESET, rdata[CSB_CTRL_ENABLE])
		apb(1'b0, CSB_ADDR_COUNT, 32'h0);
		`CHK("count after reset", CSB_COUNT_RESET, rdata[15:0])
		$display("test second reset done");
		test_done();
	end

endmodule

`undef CHK
`default_nettype wire
